// >>> serial_sram_mode_and_multi_io_control_tb.sv
// self-checking bench for the serial sram link engine
`timescale 1ns/1ps
module serial_sram_mode_and_multi_io_control_tb;
  import ssm_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b1;
  logic sck, chip_select_n;
  logic [3:0] host_o, io_out, io_oe, io_wire;
  logic [1:0] width_status, access_mode_status;
  logic [7:0] r[$];
  logic [15:0] a;
  logic [7:0] d0, d1, x;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;

  // device wins where it drives, host owns the rest
  assign io_wire = (io_oe & io_out) | (~io_oe & host_o);
  ssm_ctrl i_ssm_ctrl (.clock(clock), .resetn(resetn), .sck(sck),
    .chip_select_n(chip_select_n), .io_in(io_wire), .io_out(io_out),
    .io_oe(io_oe), .width_status(width_status),
    .access_mode_status(access_mode_status));
  ssm_host host (.sck(sck), .chip_select_n(chip_select_n),
    .host_o(host_o), .io_wire(io_wire));

  initial forever #10 clock = ~clock;

  // traffic needs about 4100 cycles; a hang is cut well after that
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  function automatic logic [15:0] nxt(input logic [15:0] ad, input logic [1:0] m);
    return (m == mode_page) ? {ad[15:5], ad[4:0] + 5'h01} : ad + 16'h0001;
  endfunction : nxt

  // upper address byte is random since the device ignores it
  task automatic wr(input logic [15:0] ad, input logic [7:0] b0, b1);
    host.run('{write_cmd, 8'($urandom), ad[15:8], ad[7:0], b0, b1}, r);
  endtask : wr

  task automatic rd(input logic [15:0] ad);
    host.run('{read_cmd, 8'($urandom), ad[15:8], ad[7:0], 8'h00, 8'h00,
      8'h00}, r);
  endtask : rd

  task automatic setm(input logic [1:0] m);
    host.run('{write_mode_register_cmd, {m, mode_reserved_value}}, r);
    chk("mode status", 8'(m), 8'(access_mode_status));
    host.run('{read_mode_register_cmd, 8'h00}, r);
    chk("mode reg", r[1], {m, 6'h00});
  endtask : setm

  initial begin
    void'($urandom(6299));
    // a real falling edge, so the async resets fire while sck stands still
    #2 resetn = 1'b0;
    repeat (5) @(posedge clock);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("mode status", 8'(mode_seq), 8'(access_mode_status));
    a = 16'($urandom) & 16'hFFE0;
    d0 = 8'($urandom);
    d1 = ~d0;
    x = 8'($urandom);
    wr(a, x, ~x);
    setm(mode_byte);
    wr(a, d0, d1);
    setm(mode_seq);
    rd(a);
    chk("byte mode", r[5], d0);
    chk("byte mode rest", r[6], ~x);
    setm(mode_page);
    wr(a + 16'd31, d0, d1);
    rd(a + 16'd31);
    chk("page rd wrap", r[6], d1);
    setm(mode_seq);
    rd(nxt(a + 16'd31, mode_page));
    chk("page wr wrap", r[5], d1);
    wr(16'hFFFF, d0, d1);
    rd(nxt(16'hFFFF, mode_seq));
    chk("seq wrap", r[5], d1);
    for (int w = 0; w < 3; w++) begin
      if (w == 1)
        host.run('{enter_dual_cmd}, r);
      if (w == 2)
        host.run('{enter_quad_cmd}, r);
      host.wd = 2'(w);
      chk("width", 8'(w), 8'(width_status));
      repeat (4) begin
        a = 16'($urandom);
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        wr(a, d0, d1);
        rd(a);
        chk("data", r[5], d0);
        chk("data next", r[6], d1);
      end
      host.run('{read_mode_register_cmd, 8'h00}, r);
      chk("mode reg", r[1], {mode_seq, 6'h00});
      host.run('{reset_multi_io_cmd}, r);
      host.wd = width_single;
      chk("width", 8'(width_single), 8'(width_status));
    end
    // power cycle while quad and page are set: both must fall back
    setm(mode_page);
    host.run('{enter_quad_cmd}, r);
    chk("width", 8'(quad_io_mode), 8'(width_status));
    @(posedge clock);
    #1 resetn = 1'b0;
    repeat (5) @(posedge clock);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("width", 8'(width_reset), 8'(width_status));
    chk("mode status", 8'(mode_seq), 8'(access_mode_status));
    host.run('{read_mode_register_cmd, 8'h00}, r);
    chk("mode reg", {mode_seq, 6'h00}, r[1]);
    give_verdict();
  end
endmodule : serial_sram_mode_and_multi_io_control_tb

// >>> ssm_array.sv
// 64k x 8 storage array with registered read data
`timescale 1ns/1ps
module ssm_array #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // access port
  input wire logic we,
  input wire logic re,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule : ssm_array

// >>> ssm_ctrl.sv
// serial sram link engine: commands, mode register, width switching
`timescale 1ns/1ps
module ssm_ctrl (
  // system clock and power-on reset
  input wire logic clock,
  input wire logic resetn,
  // serial link
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // status in the system clock domain
  output logic [1:0] width_status,
  output logic [1:0] access_mode_status
);
  import ssm_pkg::*;

  typedef struct packed {
    logic [1:0] width;
    logic [1:0] mode;
  } ssm_cfg_s;

  typedef struct packed {
    ssm_state_e state;
    logic is_read;
    logic [4:0] cnt;
    logic [23:0] sh;
    logic [15:0] addr;
    logic [7:0] tx;
  } ssm_frame_s;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
  } ssm_out_s;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] status;
  } ssm_sys_s;

  ssm_cfg_s cfg_reg, cfg_next;
  ssm_frame_s fr_reg, fr_next;
  ssm_out_s out_reg, out_next;
  ssm_sys_s sys_reg, sys_next;

  logic frame_rstn;
  logic mem_we;
  logic mem_re;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata;
  logic [23:0] shin;
  logic [4:0] byte_m1;
  logic [4:0] addr_m1;
  logic [7:0] tx_shift;
  logic byte_done;

  // deselect clears the frame but never the config; async since sck stops
  assign frame_rstn = resetn & ~chip_select_n; // RULE15 RULE17

  function automatic logic [15:0] next_addr(input logic [15:0] a,
                                            input logic [1:0] m);
    logic [15:0] r;
    r = a + 16'h0001; // RULE14
    if (m == mode_page) begin
      r = {a[15:page_bits], a[page_bits-1:0] + 5'h01}; // RULE13
    end
    return r;
  endfunction : next_addr

  // width-dependent shifting and field lengths
  always_comb begin
    case (cfg_reg.width)
      dual_io_mode: begin
        shin = {fr_reg.sh[21:0], io_in[1], io_in[0]}; // RULE6
        tx_shift = {fr_reg.tx[5:0], 2'h0};
        byte_m1 = byte_clks_dual;
        addr_m1 = addr_clks_dual;
      end
      quad_io_mode: begin
        shin = {fr_reg.sh[19:0], io_in[3:0]}; // RULE7
        tx_shift = {fr_reg.tx[3:0], 4'h0};
        byte_m1 = byte_clks_quad; // RULE16
        addr_m1 = addr_clks_quad; // RULE16
      end
      default: begin
        shin = {fr_reg.sh[22:0], io_in[0]};
        tx_shift = {fr_reg.tx[6:0], 1'h0};
        byte_m1 = byte_clks_single;
        addr_m1 = addr_clks_single;
      end
    endcase
  end

  assign byte_done = (fr_reg.cnt == byte_m1);

  // link engine, sampled on sck rising edges
  always_comb begin
    cfg_next = cfg_reg;
    fr_next = fr_reg;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_addr = fr_reg.addr;
    fr_next.cnt = byte_done ? 5'h00 : fr_reg.cnt + 5'h01;
    case (fr_reg.state)
      st_cmd: begin
        fr_next.sh = shin;
        if (byte_done) begin
          case (shin[7:0])
            read_cmd: begin
              fr_next.is_read = 1'b1;
              fr_next.state = st_addr; // RULE12
            end
            write_cmd: begin
              fr_next.is_read = 1'b0;
              fr_next.state = st_addr; // RULE12
            end
            read_mode_register_cmd: begin
              fr_next.tx = {cfg_reg.mode, mode_reserved_value}; // RULE1
              fr_next.state = st_mode_rd;
            end
            write_mode_register_cmd: begin
              fr_next.state = st_mode_wr;
            end
            enter_dual_cmd: begin
              cfg_next.width = dual_io_mode; // RULE6
              fr_next.state = st_idle;
            end
            enter_quad_cmd: begin
              cfg_next.width = quad_io_mode; // RULE7
              fr_next.state = st_idle;
            end
            reset_multi_io_cmd: begin
              cfg_next.width = width_single; // RULE8
              fr_next.state = st_idle;
            end
            default: begin
              fr_next.state = st_idle;
            end
          endcase
        end
      end
      st_addr: begin
        fr_next.sh = shin;
        fr_next.cnt = fr_reg.cnt + 5'h01;
        if (fr_reg.cnt == addr_m1) begin
          // upper address bits fall away here
          fr_next.cnt = 5'h00;
          fr_next.addr = shin[addr_bits-1:0]; // RULE12
          if (fr_reg.is_read) begin
            mem_re = 1'b1;
            mem_addr = shin[addr_bits-1:0];
            fr_next.state = st_dummy; // RULE9 RULE16
          end else begin
            fr_next.state = st_wdata; // RULE10
          end
        end
      end
      st_dummy: begin
        // one dummy byte at the current width also hides array latency
        if (byte_done) begin
          fr_next.tx = mem_rdata;
          mem_re = 1'b1;
          mem_addr = next_addr(fr_reg.addr, cfg_reg.mode);
          fr_next.addr = mem_addr;
          fr_next.state = st_rdata; // RULE9
        end
      end
      st_rdata: begin
        fr_next.tx = tx_shift;
        if (byte_done) begin
          if (cfg_reg.mode == mode_byte) begin
            fr_next.state = st_idle; // RULE2
          end else begin
            fr_next.tx = mem_rdata;
            mem_re = 1'b1;
            mem_addr = next_addr(fr_reg.addr, cfg_reg.mode);
            fr_next.addr = mem_addr;
          end
        end
      end
      st_wdata: begin
        fr_next.sh = shin;
        if (byte_done) begin
          mem_we = 1'b1;
          fr_next.addr = next_addr(fr_reg.addr, cfg_reg.mode);
          if (cfg_reg.mode == mode_byte) begin
            fr_next.state = st_idle; // RULE2
          end
        end
      end
      st_mode_rd: begin
        fr_next.tx = byte_done ? {cfg_reg.mode, mode_reserved_value}
                               : tx_shift; // RULE1
      end
      st_mode_wr: begin
        fr_next.sh = shin;
        if (byte_done) begin
          // reserved bits are not stored and read back as zero
          cfg_next.mode = shin[mode_field_hi:mode_field_lo]; // RULE5 RULE2
          fr_next.state = st_idle;
        end
      end
      default: begin
        fr_next.cnt = fr_reg.cnt;
      end
    endcase
  end

  // output lanes, launched on sck falling edges
  always_comb begin
    out_next.dout = 4'h0;
    out_next.oe = 4'h0;
    if (fr_reg.state == st_rdata || fr_reg.state == st_mode_rd) begin
      case (cfg_reg.width)
        dual_io_mode: begin
          out_next.dout = {2'h0, fr_reg.tx[7:6]}; // RULE6
          out_next.oe = 4'h3;
        end
        quad_io_mode: begin
          out_next.dout = fr_reg.tx[7:4]; // RULE7
          out_next.oe = 4'hF;
        end
        default: begin
          out_next.dout = {2'h0, fr_reg.tx[7], 1'b0};
          out_next.oe = 4'h2;
        end
      endcase
    end
  end

  // status crossing; a value is passed on only once two samples agree
  always_comb begin
    sys_next = sys_reg;
    sys_next.s1 = {cfg_reg.width, cfg_reg.mode};
    sys_next.s2 = sys_reg.s1;
    sys_next.s3 = sys_reg.s2;
    if (sys_reg.s2 == sys_reg.s3) begin
      sys_next.status = sys_reg.s3;
    end
  end

  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= '{width: width_reset, mode: mode_reset}; // RULE3 RULE17
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  always_ff @(posedge sck or negedge frame_rstn) begin
    if (!frame_rstn) begin
      fr_reg <= '{state: st_cmd, is_read: 1'b0, cnt: 5'h00, sh: 24'h000000,
                 addr: 16'h0000, tx: 8'h00};
    end else begin
      fr_reg <= fr_next;
    end
  end

  always_ff @(negedge sck or negedge frame_rstn) begin
    if (!frame_rstn) begin
      out_reg <= '{dout: 4'h0, oe: 4'h0};
    end else begin
      out_reg <= out_next;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      // stages start agreed on the reset config, else status flickers to 00
      sys_reg <= '{default: {width_reset, mode_reset}}; // RULE3
    end else begin
      sys_reg <= sys_next;
    end
  end

  assign io_out = out_reg.dout;
  assign io_oe = out_reg.oe;
  assign width_status = sys_reg.status[3:2];
  assign access_mode_status = sys_reg.status[1:0];

  ssm_array #(
    .ADDR_W(addr_bits),
    .DATA_W(8)
  ) u_array (
    .clk(sck),
    .resetn(resetn),
    .we(mem_we),
    .re(mem_re),
    .addr(mem_addr),
    .wdata(shin[7:0]),
    .rdata(mem_rdata)
  );

endmodule : ssm_ctrl

// >>> ssm_ctrl_asserts.sv
// concurrent checks on the link engine ports
`timescale 1ns/1ps
module ssm_ctrl_asserts
  import ssm_pkg::*;
(
  // clocks and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic sck,
  // link
  input wire logic chip_select_n,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  // status
  input wire logic [1:0] width_status,
  input wire logic [1:0] access_mode_status
);
  logic [5:0] cnt_reg;
  logic [7:0] sh_reg;
  wire single = (width_status == width_single);

  // edge count within a frame; deselect clears it as the engine does
  always_ff @(posedge sck or posedge chip_select_n or negedge resetn) begin
    if (!resetn || chip_select_n) begin
      cnt_reg <= 6'h00;
      sh_reg <= 8'h00;
    end else begin
      cnt_reg <= (cnt_reg == 6'h3F) ? cnt_reg : cnt_reg + 6'h01;
      sh_reg <= (cnt_reg < 6'h08) ? {sh_reg[6:0], io_in[0]} : sh_reg;
    end
  end

  a_oe_idle_deselect: assert property (@(posedge clock)
    disable iff (!resetn) chip_select_n |-> io_oe == 4'h0)
    else $error("outputs enabled while deselected");
  a_oe_by_width: assert property (@(posedge sck)
    disable iff (!resetn) io_oe != 4'h0 |-> io_oe == (single ? 4'h2 :
    (width_status == dual_io_mode) ? 4'h3 : 4'hF))
    else $error("output enables do not match width");
  a_mode_read_out: assert property (@(posedge sck)
    disable iff (!resetn || chip_select_n) cnt_reg == 6'h07 && single
    && {sh_reg[6:0], io_in[0]} == read_mode_register_cmd |=> io_oe == 4'h2
    && io_out[1] == access_mode_status[1])
    else $error("mode byte not launched after command");
  a_read_dummy_quiet: assert property (@(posedge sck)
    disable iff (!resetn || chip_select_n) sh_reg == read_cmd && single
    && cnt_reg inside {[6'h08:6'h26]} |=> io_oe == 4'h0)
    else $error("read data before end of dummy byte");
  a_read_first_data: assert property (@(posedge sck)
    disable iff (!resetn || chip_select_n)
    sh_reg == read_cmd && single && cnt_reg == 6'h27 |=> io_oe == 4'h2)
    else $error("read data missing after dummy byte");
  a_write_no_drive: assert property (@(posedge sck)
    disable iff (!resetn) sh_reg == write_cmd && single
    && cnt_reg > 6'h07 |-> io_oe == 4'h0)
    else $error("device drives during write");
  a_mode_after_reset: assert property (@(posedge clock)
    disable iff (!resetn) $rose(resetn) |-> access_mode_status == mode_reset)
    else $error("access mode not sequential after reset");
  a_width_after_reset: assert property (@(posedge clock)
    disable iff (!resetn) $rose(resetn) |-> width_status == width_reset)
    else $error("width not single after reset");
  a_status_kept_idle: assert property (@(posedge clock)
    disable iff (!resetn) chip_select_n [*8] |->
    $stable(width_status) && $stable(access_mode_status))
    else $error("status changed while deselected");

  c_dual: cover property (@(posedge clock) width_status == dual_io_mode);
  c_quad: cover property (@(posedge clock) width_status == quad_io_mode);
  c_page: cover property (@(posedge clock) access_mode_status == mode_page);
endmodule : ssm_ctrl_asserts

bind ssm_ctrl ssm_ctrl_asserts u_chk (.clock(clock), .resetn(resetn),
  .sck(sck), .chip_select_n(chip_select_n), .io_in(io_in),
  .io_out(io_out), .io_oe(io_oe), .width_status(width_status),
  .access_mode_status(access_mode_status));

// >>> ssm_host.sv
// host controller model driving the serial link
`timescale 1ns/1ps
module ssm_host (
  // link pins
  output logic sck,
  output logic chip_select_n,
  output logic [3:0] host_o,
  input wire logic [3:0] io_wire
);
  import ssm_pkg::*;
  logic [1:0] wd = width_single;

  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    host_o = 4'h0;
  end

  // one byte each way at the current width, msb first
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    int k;
    k = (wd == quad_io_mode) ? 4 : (wd == dual_io_mode) ? 2 : 1;
    rx = 8'h00;
    for (int i = 8 - k; i >= 0; i -= k) begin
      host_o = 4'((tx >> i) & ((1 << k) - 1));
      #24;
      rx = (rx << k) | 8'((k == 1) ? io_wire[1] : io_wire & 4'((1 << k) - 1));
      sck = 1'b1;
      #24;
      sck = 1'b0;
    end
  endtask : xb

  // whole frame; sck stands low outside it
  task automatic run(input logic [7:0] q[$], output logic [7:0] rq[$]);
    logic [7:0] b;
    rq = {};
    chip_select_n = 1'b0;
    #24;
    foreach (q[i]) begin
      xb(q[i], b);
      rq.push_back(b);
    end
    #24;
    chip_select_n = 1'b1;
    host_o = ~host_o;
    // gap long enough for the status crossing to settle
    #240;
  endtask : run
endmodule : ssm_host

// >>> ssm_pkg.sv
// constants and types for the serial sram mode and multi-io control
// How it works
// RULE1 - Command 05h shifts the 8-bit operating mode register out, whatever the transfer setup.
// RULE2 - Mode bits 7:6 choose byte (00), page (10) or sequential (01) access, with 11 reserved.
// RULE3 - From reset until the first mode write the access mode is sequential (01).
// RULE4 - The host writes zeros to mode register bits 5:0, which are reserved.
// RULE5 - Command 01h plus one data byte updates the writable mode bits for later transfers.
// RULE6 - After command 3Bh every later frame moves two bits per clock on lines 0 and 1, MSB first.
// RULE7 - After command 38h every later frame moves one nibble per clock on lines 0 to 3, MSB first.
// RULE8 - Command FFh, sent at the current width, returns the link to single-line operation.
// RULE9 - A dual-width read waits four clocks (one dummy byte) between address and data.
// RULE10 - A dual-width write takes data on the clocks right after the address, with no dummy.
// RULE11 - A host that resets alone must find the link width and send FFh at that width.
// RULE12 - Read 03h and write 02h take a 24-bit MSB-first address whose upper bits are ignored.
// RULE13 - Page access increments within a 32-byte page and wraps to that page's start.
// RULE14 - Sequential access increments across pages and rolls over to address zero.
// RULE15 - The host holds chip_select_n low for a whole sequence; raising it ends the transfer.
// RULE16 - At quad width a command takes two clocks, an address six, and reads have a dummy gap.
// RULE17 - Link width and mode register survive deselection; only commands or reset change them.
package ssm_pkg;

  localparam logic [7:0] read_cmd = 8'h03;
  localparam logic [7:0] write_cmd = 8'h02;
  localparam logic [7:0] read_mode_register_cmd = 8'h05;
  localparam logic [7:0] write_mode_register_cmd = 8'h01;
  localparam logic [7:0] enter_dual_cmd = 8'h3B;
  localparam logic [7:0] enter_quad_cmd = 8'h38;
  localparam logic [7:0] reset_multi_io_cmd = 8'hFF;

  // access mode field of the operating mode register
  localparam int mode_field_hi = 7;
  localparam int mode_field_lo = 6;
  localparam logic [1:0] mode_byte = 2'h0;
  localparam logic [1:0] mode_page = 2'h2;
  localparam logic [1:0] mode_seq = 2'h1;
  localparam logic [1:0] mode_reset = mode_seq;
  localparam logic [5:0] mode_reserved_value = 6'h00;

  // link widths
  localparam logic [1:0] width_single = 2'h0;
  localparam logic [1:0] dual_io_mode = 2'h1;
  localparam logic [1:0] quad_io_mode = 2'h2;
  localparam logic [1:0] width_reset = width_single;

  // clocks per byte and per address, less one, at each width
  localparam logic [4:0] byte_clks_single = 5'h07;
  localparam logic [4:0] byte_clks_dual = 5'h03;
  localparam logic [4:0] byte_clks_quad = 5'h01;
  localparam logic [4:0] addr_clks_single = 5'h17;
  localparam logic [4:0] addr_clks_dual = 5'h0B;
  localparam logic [4:0] addr_clks_quad = 5'h05;

  localparam int addr_bits = 16;
  localparam int page_bits = 5;
  localparam int wire_addr_bits = 24;

  typedef enum logic [2:0] {
    st_cmd, st_addr, st_dummy, st_rdata, st_wdata,
    st_mode_rd, st_mode_wr, st_idle
  } ssm_state_e;

endpackage : ssm_pkg
